// ==== msg_pkg.sv ====
// Constants used by the messaging requester; its bus master engine imports none of them
package msg_pkg;

	// Operation codes placed in the first control word
	localparam logic [15:0] OP_READ_WRITE  = 16'h0017;
	localparam logic [15:0] OP_SERVICE     = 16'hfff0;
	localparam logic [15:0] OP_GET_STATS   = 16'h0007;
	localparam logic [15:0] OP_CLEAR_STATS = 16'h0008;

	// Length of each parameter block in words
	localparam logic [3:0] WORDS_READ_WRITE = 4'hb;
	localparam logic [3:0] WORDS_SERVICE    = 4'h9;
	localparam logic [3:0] WORDS_STATS      = 4'h9;

	// Control word indices, counted from one
	localparam logic [3:0] W_OPERATION = 4'h1;
	localparam logic [3:0] W_EVENT     = 4'h2;
	localparam logic [3:0] W_COUNT     = 4'h3;
	localparam logic [3:0] W_START     = 4'h4;
	localparam logic [3:0] W_ROUTE     = 4'h5;
	localparam logic [3:0] W_IP_BYTE4  = 4'h6;
	localparam logic [3:0] W_IP_BYTE3  = 4'h7;
	localparam logic [3:0] W_IP_BYTE2  = 4'h8;
	localparam logic [3:0] W_IP_BYTE1  = 4'h9;
	localparam logic [3:0] W_RD_COUNT  = 4'ha;
	localparam logic [3:0] W_RD_START  = 4'hb;
	localparam logic [3:0] W_MODE      = 4'h6;
	localparam logic [3:0] W_ZERO      = 4'h7;

	// Fixed values of the service-control block
	localparam logic [15:0] SERVICE_WORD3 = 16'h0001;
	localparam logic [15:0] SERVICE_WORD7 = 16'h0000;
	localparam int          MODE_FTP_BIT  = 0;
	localparam int          MODE_HTTP_BIT = 1;

	// Event codes returned in the second control word
	localparam logic [15:0] EV_SUCCESS  = 16'h0000;
	localparam logic [15:0] EV_BUSY     = 16'h5068;
	localparam logic [15:0] EV_SAME     = 16'h4001;
	localparam logic [15:0] EV_INVALID  = 16'h2004;
	localparam logic [15:0] EV_DISABLED = 16'h5069;

	// Software register offsets on the APB slave
	localparam logic [11:0] ADDR_CTRL    = 12'h000;
	localparam logic [11:0] ADDR_ROUTE   = 12'h004;
	localparam logic [11:0] ADDR_IP      = 12'h008;
	localparam logic [11:0] ADDR_WR_SPAN = 12'h00c;
	localparam logic [11:0] ADDR_RD_SPAN = 12'h010;
	localparam logic [11:0] ADDR_SERVICE = 12'h014;
	localparam logic [11:0] ADDR_BASE    = 12'h018;
	localparam logic [11:0] ADDR_STATUS  = 12'h01c;

	// Field positions
	localparam int CTRL_GO_BIT     = 16;
	localparam int ST_BUSY         = 0;
	localparam int ST_DONE         = 1;
	localparam int ST_BAD_OP       = 2;
	localparam int ST_BUS_ERR      = 3;
	localparam int ST_SUCCESS      = 4;
	localparam int ST_DEV_BUSY     = 5;
	localparam int ST_SAME         = 6;
	localparam int ST_INVALID      = 7;
	localparam int ST_DISABLED     = 8;
	localparam int ST_EVENT_LSB    = 16;

	// Reset values
	localparam logic [31:0] RST_WORD32 = 32'h0000_0000;
	localparam logic [15:0] RST_WORD16 = 16'h0000;
	localparam logic [15:0] RST_OP     = 16'h0017;

	// Sequencer states, one-hot
	typedef enum logic [3:0] {
		SEQ_IDLE    = 4'b0001,
		SEQ_FILL    = 4'b0010,
		SEQ_TRIGGER = 4'b0100,
		SEQ_FETCH   = 4'b1000
	} seq_state_t;

endpackage : msg_pkg

// ==== apb_word_master.sv ====
// APB master engine that runs one word transfer per start pulse
`timescale 1ns/1ps
module apb_word_master (
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic        clockEnable,
	input  wire logic        start,
	input  wire logic        writeReq,
	input  wire logic [31:0] address,
	input  wire logic [31:0] writeData,
	output logic             done,
	output logic             fault,
	output logic [31:0]      readData,
	output logic             mPsel,
	output logic             mPenable,
	output logic             mPwrite,
	output logic [31:0]      mPaddr,
	output logic [31:0]      mPwdata,
	input  wire logic [31:0] mPrdata,
	input  wire logic        mPready,
	input  wire logic        mPslverr
);

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] paddr;
		logic [31:0] pwdata;
		logic [31:0] rdata;
		logic        done;
		logic        fault;
	} master_state_t;

	master_state_t r;
	master_state_t next_r;

	// Setup, then access held until the slave answers; no cycle count assumed
	always_comb begin
		next_r      = r;
		next_r.done = 1'b0;
		if (r.psel && r.penable) begin
			if (mPready) begin
				next_r.psel    = 1'b0;
				next_r.penable = 1'b0;
				next_r.done    = 1'b1;
				next_r.fault   = mPslverr;
				next_r.rdata   = mPrdata;
			end
		end else if (r.psel) begin
			next_r.penable = 1'b1;
		end else if (start) begin
			next_r.psel   = 1'b1;
			next_r.pwrite = writeReq;
			next_r.paddr  = address;
			next_r.pwdata = writeData;
		end
	end

	// Whole state frozen while the clock enable is low
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			r <= '0;
		end else if (clockEnable) begin
			r <= next_r;
		end
	end

	assign done     = r.done;
	assign fault    = r.fault;
	assign readData = r.rdata;
	assign mPsel    = r.psel;
	assign mPenable = r.penable;
	assign mPwrite  = r.pwrite;
	assign mPaddr   = r.paddr;
	assign mPwdata  = r.pwdata;

endmodule : apb_word_master

// ==== messaging_requester.sv ====
// Requester that builds messaging control blocks in a remote module over APB
// How it works
// (R01) Operation 23 is the combined write-then-read, using eleven control words.
// (R02) Word three carries the count of words written to the remote slave.
// (R03) Word four carries the first remote memory word index to write.
// (R04) Word five: upper byte module slot, lower byte transporter mapping index.
// (R05) Words six to nine carry the IP address, most significant octet first.
// (R06) Word ten carries the count of words read back.
// (R07) Word eleven carries the first remote memory word index to read.
// (R08) Device returns the event code in word two; requester only reads it.
// (R09) Operation 0xfff0 is service enable or disable, using nine words.
// (R10) Device returns 0x000 when a service state really changed.
// (R11) Device answers 0x5068 busy within two seconds of previous service call.
// (R12) Device answers 0x4001 when requested states equal current ones.
// (R13) Device answers 0x2004 for a malformed service block.
// (R14) Device answers 0x5069 for a service disabled by configuration.
// (R15) Service requests put 1 in word three.
// (R16) Service requests put 0 in word seven.
// (R17) Service word five: upper byte slot, lower byte destination identifier.
// (R18) Word six bit 0 enables file transfer, bit 1 enables web.
// (R19) Run-time service states revert to configuration on restart or download.
// (R20) A service disabled at run time stays so until re-enabled or restarted.
// (R21) Operations 7 and 8 get and clear remote statistics, nine words each.
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module messaging_requester (
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic        clockEnable,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             mPsel,
	output logic             mPenable,
	output logic             mPwrite,
	output logic [31:0]      mPaddr,
	output logic [31:0]      mPwdata,
	input  wire logic [31:0] mPrdata,
	input  wire logic        mPready,
	input  wire logic        mPslverr
);

	typedef struct packed {
		logic [15:0]         op;
		logic [15:0]         route;
		logic [31:0]         ip;
		logic [31:0]         wrSpan;
		logic [31:0]         rdSpan;
		logic [1:0]          mode;
		logic [31:0]         base;
		msg_pkg::seq_state_t seq;
		logic [3:0]          word;
		logic                issued;
		logic                done;
		logic                badOp;
		logic                busErr;
		logic [15:0]         eventCode;
		logic                pready;
		logic                pslverr;
		logic [31:0]         prdata;
	} top_state_t;

	top_state_t r;
	top_state_t next_r;

	logic        start;
	logic        writeReq;
	logic [31:0] wordAddress;
	logic [31:0] wordData;
	logic        xferDone;
	logic        xferFault;
	logic [31:0] xferData;
	logic        access;
	logic [31:0] statusWord;

	// Number of words in the block that an operation code selects
	function automatic logic [3:0] blockLength(input logic [15:0] op);
		case (op)
			// (R01) eleven words
			msg_pkg::OP_READ_WRITE:  blockLength = msg_pkg::WORDS_READ_WRITE;
			// (R09) nine words
			msg_pkg::OP_SERVICE:     blockLength = msg_pkg::WORDS_SERVICE;
			// (R21) statistics layout
			msg_pkg::OP_GET_STATS,
			msg_pkg::OP_CLEAR_STATS: blockLength = msg_pkg::WORDS_STATS;
			default:                 blockLength = 4'h0;
		endcase
	endfunction : blockLength

	// Value of control word k for the operation held in the registers
	function automatic logic [15:0] controlWord(input top_state_t s, input logic [3:0] k);
		logic svc;
		logic rw;
		svc = (s.op == msg_pkg::OP_SERVICE);
		rw  = (s.op == msg_pkg::OP_READ_WRITE);
		controlWord = msg_pkg::RST_WORD16;
		case (k)
			msg_pkg::W_OPERATION: controlWord = s.op;
			msg_pkg::W_COUNT: begin
				// (R15) service fixed one
				if (svc) begin
					controlWord = msg_pkg::SERVICE_WORD3;
				// (R02) write count
				end else if (s.op != msg_pkg::OP_CLEAR_STATS) begin
					controlWord = s.wrSpan[15:0];
				end
			end
			msg_pkg::W_START: begin
				// (R03) write start index
				if (!svc && s.op != msg_pkg::OP_CLEAR_STATS) begin
					controlWord = s.wrSpan[31:16];
				end
			end
			// (R04) slot and mapping
			// (R17) slot and destination
			msg_pkg::W_ROUTE: controlWord = s.route;
			msg_pkg::W_IP_BYTE4: begin
				// (R18) service mode bits
				if (svc) begin
					controlWord = {14'h0000, s.mode[msg_pkg::MODE_HTTP_BIT],
						s.mode[msg_pkg::MODE_FTP_BIT]};
				// (R05) most significant octet
				end else begin
					controlWord = {8'h00, s.ip[31:24]};
				end
			end
			msg_pkg::W_IP_BYTE3: begin
				// (R16) service fixed zero
				if (svc) begin
					controlWord = msg_pkg::SERVICE_WORD7;
				end else begin
					controlWord = {8'h00, s.ip[23:16]};
				end
			end
			// (R05) lower octets
			msg_pkg::W_IP_BYTE2: controlWord = svc ? 16'h0000 : {8'h00, s.ip[15:8]};
			msg_pkg::W_IP_BYTE1: controlWord = svc ? 16'h0000 : {8'h00, s.ip[7:0]};
			// (R06) read count
			msg_pkg::W_RD_COUNT: controlWord = rw ? s.rdSpan[15:0] : 16'h0000;
			// (R07) read start index
			msg_pkg::W_RD_START: controlWord = rw ? s.rdSpan[31:16] : 16'h0000;
			default:             controlWord = 16'h0000;
		endcase
	endfunction : controlWord

	// Status word; device codes decoded so software need not compare them
	always_comb begin
		statusWord = 32'h0000_0000;
		statusWord[msg_pkg::ST_BUSY]    = (r.seq != msg_pkg::SEQ_IDLE);
		statusWord[msg_pkg::ST_DONE]    = r.done;
		statusWord[msg_pkg::ST_BAD_OP]  = r.badOp;
		statusWord[msg_pkg::ST_BUS_ERR] = r.busErr;
		// (R10) success decode
		statusWord[msg_pkg::ST_SUCCESS] = r.done && (r.eventCode == msg_pkg::EV_SUCCESS);
		// (R11) busy decode
		statusWord[msg_pkg::ST_DEV_BUSY] = r.done && (r.eventCode == msg_pkg::EV_BUSY);
		// (R12) same state decode
		statusWord[msg_pkg::ST_SAME] = r.done && (r.eventCode == msg_pkg::EV_SAME);
		// (R13) invalid data decode
		statusWord[msg_pkg::ST_INVALID] = r.done && (r.eventCode == msg_pkg::EV_INVALID);
		// (R14) disabled decode
		statusWord[msg_pkg::ST_DISABLED] = r.done && (r.eventCode == msg_pkg::EV_DISABLED);
		statusWord[msg_pkg::ST_EVENT_LSB +: 16] = r.eventCode;
	end

	// Request to the bus engine: words are written except the event fetch
	assign access      = psel && penable && !r.pready;
	assign start       = (r.seq != msg_pkg::SEQ_IDLE) && !r.issued;
	assign writeReq    = (r.seq != msg_pkg::SEQ_FETCH);
	assign wordAddress = r.base + {26'h0000000, r.word, 2'b00};
	assign wordData    = {16'h0000, controlWord(r, r.word)};

	// Register slave and block sequencer
	always_comb begin
		next_r         = r;
		next_r.pready  = 1'b0;
		next_r.pslverr = 1'b0;
		next_r.prdata  = 32'h0000_0000;

		// One wait state on every slave access; settings locked while busy
		if (access) begin
			next_r.pready = 1'b1;
			case (paddr)
				msg_pkg::ADDR_CTRL: begin
					next_r.prdata = {16'h0000, r.op};
					if (pwrite && r.seq == msg_pkg::SEQ_IDLE) begin
						next_r.op = pwdata[15:0];
						if (pwdata[msg_pkg::CTRL_GO_BIT]) begin
							next_r.done   = 1'b0;
							next_r.busErr = 1'b0;
							next_r.badOp  = (blockLength(pwdata[15:0]) == 4'h0);
							if (blockLength(pwdata[15:0]) != 4'h0) begin
								// (R08) word two skipped, device owns it
								next_r.seq  = msg_pkg::SEQ_FILL;
								next_r.word = msg_pkg::W_COUNT;
							end
						end
					end
				end
				msg_pkg::ADDR_ROUTE: begin
					next_r.prdata = {16'h0000, r.route};
					if (pwrite && r.seq == msg_pkg::SEQ_IDLE) next_r.route = pwdata[15:0];
				end
				msg_pkg::ADDR_IP: begin
					next_r.prdata = r.ip;
					if (pwrite && r.seq == msg_pkg::SEQ_IDLE) next_r.ip = pwdata;
				end
				msg_pkg::ADDR_WR_SPAN: begin
					next_r.prdata = r.wrSpan;
					if (pwrite && r.seq == msg_pkg::SEQ_IDLE) next_r.wrSpan = pwdata;
				end
				msg_pkg::ADDR_RD_SPAN: begin
					next_r.prdata = r.rdSpan;
					if (pwrite && r.seq == msg_pkg::SEQ_IDLE) next_r.rdSpan = pwdata;
				end
				msg_pkg::ADDR_SERVICE: begin
					next_r.prdata = {30'h00000000, r.mode};
					if (pwrite && r.seq == msg_pkg::SEQ_IDLE) next_r.mode = pwdata[1:0];
				end
				msg_pkg::ADDR_BASE: begin
					next_r.prdata = r.base;
					if (pwrite && r.seq == msg_pkg::SEQ_IDLE) next_r.base = pwdata;
				end
				msg_pkg::ADDR_STATUS: next_r.prdata = statusWord;
				default:              next_r.pslverr = 1'b1;
			endcase
		end

		// Block sequencer: parameters, then operation word last, then event code
		if (xferDone) begin
			next_r.issued = 1'b0;
			next_r.busErr = r.busErr || xferFault;
			case (r.seq)
				msg_pkg::SEQ_FILL: begin
					if (r.word == blockLength(r.op)) begin
						// Operation word goes last so the block is whole when it fires
						next_r.seq  = msg_pkg::SEQ_TRIGGER;
						next_r.word = msg_pkg::W_OPERATION;
					end else begin
						next_r.word = r.word + 4'h1;
					end
				end
				msg_pkg::SEQ_TRIGGER: begin
					next_r.seq  = msg_pkg::SEQ_FETCH;
					next_r.word = msg_pkg::W_EVENT;
				end
				msg_pkg::SEQ_FETCH: begin
					// (R08) event code read back
					next_r.eventCode = xferData[15:0];
					next_r.done      = 1'b1;
					next_r.seq       = msg_pkg::SEQ_IDLE;
				end
				default: next_r.seq = msg_pkg::SEQ_IDLE;
			endcase
		end else if (start) begin
			next_r.issued = 1'b1;
		end
	end

	// Whole state frozen while the clock enable is low
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			r           <= '0;
			r.op        <= msg_pkg::RST_OP;
			r.base      <= msg_pkg::RST_WORD32;
			r.eventCode <= msg_pkg::RST_WORD16;
			r.seq       <= msg_pkg::SEQ_IDLE;
		end else if (clockEnable) begin
			r <= next_r;
		end
	end

	apb_word_master bus (
		.clock       (clock),
		.rst_b       (rst_b),
		.clockEnable (clockEnable),
		.start       (start),
		.writeReq    (writeReq),
		.address     (wordAddress),
		.writeData   (wordData),
		.done        (xferDone),
		.fault       (xferFault),
		.readData    (xferData),
		.mPsel       (mPsel),
		.mPenable    (mPenable),
		.mPwrite     (mPwrite),
		.mPaddr      (mPaddr),
		.mPwdata     (mPwdata),
		.mPrdata     (mPrdata),
		.mPready     (mPready),
		.mPslverr    (mPslverr)
	);

	assign prdata  = r.prdata;
	assign pready  = r.pready;
	assign pslverr = r.pslverr;

endmodule : messaging_requester

// ==== messaging_requester_props.sv ====
// Checker of the requester's software and remote APB ports
`timescale 1ns/1ps
module messaging_requester_props (
	input wire logic        clock,
	input wire logic        rst_b,
	input wire logic        clockEnable,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        mPsel,
	input wire logic        mPenable,
	input wire logic        mPwrite,
	input wire logic [31:0] mPaddr,
	input wire logic [31:0] mPwdata,
	input wire logic        mPready
);
	// One clock domain; reset silences every check
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	// Software side answers one cycle after the access phase opens
	// A frozen clock enable holds every output, so only running cycles are timed
	a_ready_pulse: assert property (pready & clockEnable |=> !pready)
		else $error("pready too long");
	a_ready_late: assert property ($rose(psel & penable) & clockEnable |=> pready)
		else $error("pready late");
	// Unaligned offsets are unmapped as well
	a_unmapped_err: assert property ($rose(psel & penable) & clockEnable &
		(paddr > 12'h01c | paddr[1:0] != 2'b00) |=> pslverr)
		else $error("no pslverr");
	a_mapped_ok: assert property ($rose(psel & penable) & paddr < 12'h020 &
		paddr[1:0] == 2'b00 |=> !pslverr)
		else $error("spurious pslverr");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata not idle");
	// Remote request must not move before the slave takes it
	a_remote_hold: assert property (mPsel & !(mPenable & mPready) |=>
		mPsel & $stable(mPaddr) & $stable(mPwdata) & $stable(mPwrite))
		else $error("remote request moved");
	a_remote_access: assert property (mPsel & !mPenable & clockEnable |=> mPenable)
		else $error("no access phase");
	a_remote_gap: assert property (mPsel & mPenable & mPready & clockEnable |=>
		!mPsel [*2])
		else $error("gap too short");
	// Control words are sixteen bits wide
	a_word_upper: assert property (mPsel & mPwrite |-> mPwdata[31:16] == 16'h0)
		else $error("upper half set");
endmodule : messaging_requester_props

bind messaging_requester messaging_requester_props u_props (.clock, .rst_b, .clockEnable, .psel, .penable,
	.paddr, .prdata, .pready, .pslverr, .mPsel, .mPenable, .mPwrite, .mPaddr, .mPwdata, .mPready);

// ==== control_block_model.sv ====
// Behavioural model of the remote control-word block
`timescale 1ns/1ps
module control_block_model #(
	parameter int HOLD = 200
) (
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic [31:0] base,
	input  wire logic [1:0]  cfgOff,
	input  wire logic        mPsel,
	input  wire logic        mPenable,
	input  wire logic        mPwrite,
	input  wire logic [31:0] mPaddr,
	input  wire logic [31:0] mPwdata,
	output logic [31:0]      mPrdata,
	output logic             mPready,
	output logic             mPslverr
);
	logic [15:0] mem [0:15];
	logic [15:0] ev;
	logic [1:0]  svc;
	logic [1:0]  mode;
	logic [31:0] junk;
	logic [3:0]  k;
	int          since;
	int          wt;

	// Word index from byte address; an idle bus shows a toggling pattern
	assign k = 4'((mPaddr - base) >> 2);
	assign mode = mem[6][1:0];
	assign mPslverr = 1'b0;
	assign mPrdata = mPready ? {16'h0, k == 4'h2 ? ev : mem[k]} : junk;

	// Random wait of one to three cycles so slow answers are exercised too
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			svc <= ~cfgOff;
			since <= HOLD;
			mPready <= 1'b0;
			ev <= 16'h0;
			wt <= 0;
			junk <= 32'h5a5a_a5a5;
		end else begin
			junk <= ~junk;
			since <= since + 1;
			mPready <= mPsel & mPenable & !mPready & wt == 0;
			if (mPsel & mPenable & !mPready)
				wt <= wt == 0 ? $urandom_range(2) : wt - 1;
			if (mPsel & mPenable & mPready & mPwrite) begin
				mem[k] <= mPwdata[15:0];
				if (k == 4'h1)
					ev <= 16'h0000;
				if (k == 4'h1 && mPwdata[15:0] == 16'hfff0) begin
					since <= 0;
					if (since < HOLD)
						ev <= 16'h5068;
					else if (mem[3] != 16'h1 || mem[7] != 16'h0)
						ev <= 16'h2004;
					else if (|(cfgOff & (mode ^ svc)))
						ev <= 16'h5069;
					else if (mode == svc)
						ev <= 16'h4001;
					else begin
						ev <= 16'h0000;
						svc <= mode;
					end
				end
			end
		end
	end
endmodule : control_block_model

// ==== messaging_requester_bench.sv ====
// Self-checking bench of the messaging requester and a control-block model
`timescale 1ns/1ps
module messaging_requester_bench;
	localparam int HOLD = 200;
	logic        clock = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, mPaddr, mPwdata, mPrdata, r, ip, ws, rs, seed;
	logic        pready, pslverr, mPsel, mPenable, mPwrite, mPready, mPslverr;
	logic        clockEnable = 1'b1;
	logic [15:0] route, op;
	logic [33:0] expq [$], ex;
	int          n_errors = 0, num_checks = 0, cyc = 0;

	// 40 MHz clock
	always #12.5 clock = ~clock;

	// Remote block sits at byte base 0x40, web service off by configuration
	messaging_requester u_dut (.clock, .rst_b, .clockEnable, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .mPsel, .mPenable, .mPwrite, .mPaddr,
		.mPwdata, .mPrdata, .mPready, .mPslverr);
	control_block_model #(.HOLD(HOLD)) u_model (.clock, .rst_b, .base(32'h40), .cfgOff(2'b10),
		.mPsel, .mPenable, .mPwrite, .mPaddr, .mPwdata, .mPrdata, .mPready, .mPslverr);

	task automatic fail(input string m);
		n_errors++;
		$display("FAIL %0t %s", $time, m);
	endtask : fail

	task close_out;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out

	// One APB transfer; a read leaves a note of what it should return
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [33:0] e);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w)
			expq.push_back(e);
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		xfer(1'b0, a, 32'h0, {1'b1, e});
	endtask : rd

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, 34'h0);
	endtask : wr

	// Start an operation and poll status until busy clears
	task automatic go(input logic [15:0] o);
		wr(12'h000, {15'h0, 1'b1, o});
		repeat (300) begin
			xfer(1'b0, 12'h01c, 32'h0, 34'h0);
			if (r[0] === 1'b0)
				break;
		end
	endtask : go

	// Final status: event code high, done plus one decoded flag low
	task automatic run(input logic [15:0] o, input logic [15:0] ev, input int b);
		go(o);
		rd(12'h01c, {1'b0, ev, 16'h0002} | (33'h1 << b));
	endtask : run

	task automatic svc(input logic [1:0] m, input logic [15:0] ev, input int b);
		wr(12'h014, {30'h0, m});
		run(16'hfff0, ev, b);
	endtask : svc

	task automatic cmpw(input int i, input logic [15:0] e);
		num_checks++;
		if (u_model.mem[i] !== e)
			fail("control word");
	endtask : cmpw

	// Watcher: each read answer is matched with the oldest note; also the hang limit
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			fail("timeout");
			close_out();
		end
		if (psel && penable && pready && !pwrite) begin
			ex = expq.pop_front();
			if (ex[33]) begin
				num_checks++;
				if ({pslverr, prdata} !== ex[32:0])
					fail("read data");
			end
		end
	end

	// Main sequence
	initial begin
		seed = $urandom(32'h2ff7);
		repeat (16) @(posedge clock);
		rst_b <= 1'b1;
		rd(12'h000, 33'h0_0000_0017);
		rd(12'h01c, 33'h0);
		rd(12'h020, 33'h1_0000_0000);
		// Clock enable low: a read must stay unanswered until it rises again
		clockEnable <= 1'b0;
		fork
			rd(12'h004, 33'h0);
			begin
				repeat (8) @(posedge clock);
				num_checks++;
				if (psel !== 1'b1 || pready !== 1'b0)
					fail("ran while frozen");
				clockEnable <= 1'b1;
			end
		join
		route = 16'($urandom);
		ip = $urandom;
		ws = $urandom;
		rs = $urandom;
		wr(12'h018, 32'h40);
		wr(12'h004, {16'h0, route});
		wr(12'h008, ip);
		wr(12'h00c, ws);
		wr(12'h010, rs);
		run(16'h0017, 16'h0000, 4);
		cmpw(1, 16'h0017);
		cmpw(3, ws[15:0]);
		cmpw(4, ws[31:16]);
		cmpw(5, route);
		cmpw(6, {8'h0, ip[31:24]});
		cmpw(7, {8'h0, ip[23:16]});
		cmpw(8, {8'h0, ip[15:8]});
		cmpw(9, {8'h0, ip[7:0]});
		cmpw(10, rs[15:0]);
		cmpw(11, rs[31:16]);
		// Services: file transfer on, web off by configuration
		svc(2'b00, 16'h0000, 4);
		cmpw(1, 16'hfff0);
		cmpw(3, 16'h0001);
		cmpw(5, route);
		cmpw(6, 16'h0000);
		cmpw(7, 16'h0000);
		svc(2'b01, 16'h5068, 5);
		repeat (HOLD) @(posedge clock);
		svc(2'b00, 16'h4001, 6);
		repeat (HOLD) @(posedge clock);
		svc(2'b11, 16'h5069, 8);
		cmpw(6, 16'h0003);
		// Statistics operations, then an unknown code
		for (int i = 0; i < 2; i++) begin
			op = i ? 16'h0008 : 16'h0007;
			run(op, 16'h0000, 4);
			cmpw(1, op);
			cmpw(3, i ? 16'h0000 : ws[15:0]);
		end
		go(16'h000a);
		num_checks++;
		if (r[2] !== 1'b1)
			fail("unknown code accepted");
		// Restart brings back the configured states
		rst_b <= 1'b0;
		repeat (4) @(posedge clock);
		rst_b <= 1'b1;
		rd(12'h000, 33'h0_0000_0017);
		wr(12'h018, 32'h40);
		svc(2'b01, 16'h4001, 6);
		close_out();
	end
endmodule : messaging_requester_bench
